// ==== core/charger_config_registers.sv ====
`timescale 1ns/1ps
// Functional notes
// - Current register: source select, charge, termination codes
// - Source select 0: larger of code, detection
// - Source select 1: programmed code only
// - Charge code 11 mV plus 2, saturating 31
// - Termination code 1 mV plus 1 per step
// - Charging uses smaller of charge, safety current
// - Voltage register: input limit, regulation voltage codes
// - Input limit 100, 500, 975 mA, none
// - Regulation 3.50 V plus 20 mV, saturating 4.44
// - Boost code 25 gives 5 V, saturating 5.5
// - Outside boost mode, charging uses smaller of regulation, safety voltage
// - Special register bit layout, top bit down
// - Short reference: internal, or pin current source
// - Termination follows termination enable bit
// - Reduced current forces 3 mV sense
// - Input regulation 4.20 V plus 80 mV steps
// - Safety current code maps like charge code
// - Safety voltage 4.20 V plus 20, saturating 4.44
module charger_config_registers
   import charger_config_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register access port
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWriteData,
   input wire logic regRead,
   output logic [7:0] regReadData,
   output logic regReadValid,
   // Operating state and safety limits
   input wire logic charging,
   input wire logic boostMode,
   input wire logic [1:0] detectedLimitCode,
   input wire logic [3:0] maxChargeCurrentCode,
   input wire logic [3:0] maxRegulationVoltageCode,
   // External host-role pin
   input wire logic hostRolePin,
   // Effective settings
   output logic [1:0] inputLimitCode,
   output logic [9:0] inputLimitMa,
   output logic inputLimitDisabled,
   output logic [12:0] chargeSenseMv,
   output logic [12:0] terminationSenseMv,
   output logic terminationEnable,
   output logic [12:0] regulationMv,
   output logic [12:0] boostMv,
   output logic [12:0] inputDpmMv,
   output logic thresholdPinSourceEnable,
   output logic hostRoleRequest
);

   // ***************************************
   // Mapping functions
   // ***************************************
   // Base plus step times code
   function automatic logic [12:0] linearMv(input logic [12:0] baseMv, input logic [12:0] stepMv,
                                            input logic [5:0] code);
      linearMv = 13'(baseMv + stepMv * {7'h00, code});
   endfunction

   function automatic logic [12:0] chargeCodeMv(input logic [3:0] code);
      logic [3:0] sat;
      sat = (code > CHARGE_CODE_SAT) ? CHARGE_CODE_SAT : code;
      chargeCodeMv = linearMv(CHARGE_MV_BASE, CHARGE_MV_STEP, {2'h0, sat});
   endfunction

   function automatic logic [12:0] smallerMv(input logic [12:0] a, input logic [12:0] b);
      smallerMv = (a < b) ? a : b;
   endfunction

   // ***************************************
   // Register storage
   // ***************************************
   logic [7:0] chargeCurrentConfig_reg;
   logic [7:0] chargeVoltageConfig_reg;
   logic [7:0] chargerSpecialConfig_reg;
   logic [7:0] regReadData_reg;
   logic regReadValid_reg;
   logic hitCurrent;
   logic hitVoltage;
   logic hitSpecial;
   logic [7:0] readMux;
   logic writeCurrent;
   logic writeVoltage;
   logic writeSpecial;

   assign hitCurrent = (regAddr == CHARGE_CURRENT_CONFIG_OFFSET);
   assign hitVoltage = (regAddr == CHARGE_VOLTAGE_CONFIG_OFFSET);
   assign hitSpecial = (regAddr == CHARGER_SPECIAL_CONFIG_OFFSET);
   assign readMux = hitCurrent ? chargeCurrentConfig_reg :
                    hitVoltage ? chargeVoltageConfig_reg :
                    hitSpecial ? chargerSpecialConfig_reg : UNMAPPED_READ_VALUE;
   assign writeCurrent = regWrite & hitCurrent;
   assign writeVoltage = regWrite & hitVoltage;
   assign writeSpecial = regWrite & hitSpecial;

   // All bits read/write
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         chargeCurrentConfig_reg <= CHARGE_CURRENT_CONFIG_RESET;
      end else if (writeCurrent) begin
         chargeCurrentConfig_reg <= regWriteData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         chargeVoltageConfig_reg <= CHARGE_VOLTAGE_CONFIG_RESET;
      end else if (writeVoltage) begin
         chargeVoltageConfig_reg <= regWriteData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         chargerSpecialConfig_reg <= CHARGER_SPECIAL_CONFIG_RESET;
      end else if (writeSpecial) begin
         chargerSpecialConfig_reg <= regWriteData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         regReadData_reg <= UNMAPPED_READ_VALUE;
         regReadValid_reg <= 1'b0;
      end else begin
         regReadValid_reg <= regRead;
         if (regRead) regReadData_reg <= readMux;
      end
   end

   assign regReadData = regReadData_reg;
   assign regReadValid = regReadValid_reg;

   // ***************************************
   // Field extraction
   // ***************************************
   logic inputLimitSourceSelect;
   logic [3:0] chargeCurrentCode;
   logic [2:0] terminationCurrentCode;
   logic [1:0] inputCurrentLimitCode;
   logic [5:0] regulationVoltageCode;
   logic shortThresholdRefSelect;
   logic reducedChargeCurrentEnable;
   logic [2:0] inputDpmVoltageCode;

   assign inputLimitSourceSelect = chargeCurrentConfig_reg[LIMIT_SOURCE_BIT];
   assign chargeCurrentCode = chargeCurrentConfig_reg[CHARGE_CODE_MSB:CHARGE_CODE_LSB];
   assign terminationCurrentCode = chargeCurrentConfig_reg[TERM_CODE_MSB:TERM_CODE_LSB];
   assign inputCurrentLimitCode = chargeVoltageConfig_reg[INPUT_LIMIT_MSB:INPUT_LIMIT_LSB];
   assign regulationVoltageCode = chargeVoltageConfig_reg[REG_VOLT_MSB:REG_VOLT_LSB];
   assign shortThresholdRefSelect = chargerSpecialConfig_reg[SHORT_REF_BIT];
   assign reducedChargeCurrentEnable = chargerSpecialConfig_reg[REDUCED_CURRENT_BIT];
   assign inputDpmVoltageCode = chargerSpecialConfig_reg[DPM_CODE_MSB:DPM_CODE_LSB];

   // ***************************************
   // Host-role pin qualification
   // ***************************************
   host_role_if roleBus ();

   assign roleBus.pinEnable = chargerSpecialConfig_reg[HOST_ENABLE_BIT];
   assign roleBus.pinPolarity = chargerSpecialConfig_reg[HOST_POLARITY_BIT];

   host_role_qualifier u_host_role_qualifier (
      .ref_clk(ref_clk),
      .rst(rst),
      .hostRolePin(hostRolePin),
      .roleBus(roleBus)
   );

   // ***************************************
   // Input current limit
   // ***************************************
   logic [1:0] limitCode_next;
   logic [9:0] limitMa_next;

   // Code order matches rising limit, code 3 is no limit
   assign limitCode_next = inputLimitSourceSelect ? inputCurrentLimitCode :
                           (detectedLimitCode > inputCurrentLimitCode) ? detectedLimitCode :
                           inputCurrentLimitCode;
   assign limitMa_next = (limitCode_next == 2'h0) ? INPUT_LIMIT_MA_0 :
                         (limitCode_next == 2'h1) ? INPUT_LIMIT_MA_1 :
                         (limitCode_next == 2'h2) ? INPUT_LIMIT_MA_2 : INPUT_LIMIT_MA_NONE;

   // ***************************************
   // Charge and termination current
   // ***************************************
   logic [12:0] progChargeMv;
   logic [12:0] maxChargeMv;
   logic [12:0] chargeMv_next;
   logic [12:0] termMv_next;

   assign progChargeMv = chargeCodeMv(chargeCurrentCode);
   assign maxChargeMv = chargeCodeMv(maxChargeCurrentCode);
   assign chargeMv_next = reducedChargeCurrentEnable ? REDUCED_CHARGE_MV :
                          charging ? smallerMv(progChargeMv, maxChargeMv) : progChargeMv;
   assign termMv_next = linearMv(TERM_MV_BASE, TERM_MV_STEP, {3'h0, terminationCurrentCode});

   // ***************************************
   // Regulation and boost voltage
   // ***************************************
   logic [5:0] regCodeSat;
   logic [3:0] maxVoltCodeSat;
   logic [12:0] progRegMv;
   logic [12:0] maxRegMv;
   logic [12:0] regMv_next;
   logic [12:0] boostRaw;
   logic [12:0] boostMv_next;
   logic [12:0] dpmMv_next;

   assign regCodeSat = (regulationVoltageCode > REG_VOLT_CODE_SAT) ? REG_VOLT_CODE_SAT : regulationVoltageCode;
   assign progRegMv = linearMv(REG_VOLT_MV_BASE, REG_VOLT_MV_STEP, regCodeSat);
   assign maxVoltCodeSat = (maxRegulationVoltageCode > MAX_VOLT_CODE_SAT) ? MAX_VOLT_CODE_SAT :
                           maxRegulationVoltageCode;
   assign maxRegMv = linearMv(MAX_VOLT_MV_BASE, MAX_VOLT_MV_STEP, {2'h0, maxVoltCodeSat});
   assign regMv_next = charging ? smallerMv(progRegMv, maxRegMv) : progRegMv;
   // Boost steps linearly through 5 V at code 25, clipped at the top
   assign boostRaw = linearMv(BOOST_MV_BASE, BOOST_MV_STEP, regCodeSat);
   assign boostMv_next = (regCodeSat == REG_VOLT_CODE_SAT) ? BOOST_MV_MAX :
                         smallerMv(boostRaw, BOOST_MV_MAX);
   assign dpmMv_next = linearMv(DPM_MV_BASE, DPM_MV_STEP, {3'h0, inputDpmVoltageCode});

   // ***************************************
   // Output registers
   // ***************************************
   logic [1:0] inputLimitCode_reg;
   logic [9:0] inputLimitMa_reg;
   logic inputLimitDisabled_reg;
   logic [12:0] chargeSenseMv_reg;
   logic [12:0] terminationSenseMv_reg;
   logic terminationEnable_reg;
   logic [12:0] regulationMv_reg;
   logic [12:0] boostMv_reg;
   logic [12:0] inputDpmMv_reg;
   logic thresholdSource_reg;

   // Input limit outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         inputLimitCode_reg <= 2'h0;
         inputLimitMa_reg <= INPUT_LIMIT_MA_0;
         inputLimitDisabled_reg <= 1'b0;
      end else begin
         inputLimitCode_reg <= limitCode_next;
         inputLimitMa_reg <= limitMa_next;
         inputLimitDisabled_reg <= (limitCode_next == INPUT_LIMIT_NONE);
      end
   end

   // Current outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         chargeSenseMv_reg <= REDUCED_CHARGE_MV;
         terminationSenseMv_reg <= TERM_MV_BASE;
         terminationEnable_reg <= 1'b0;
      end else begin
         chargeSenseMv_reg <= chargeMv_next;
         terminationSenseMv_reg <= termMv_next;
         terminationEnable_reg <= chargerSpecialConfig_reg[TERM_ENABLE_BIT];
      end
   end

   // Voltage outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         regulationMv_reg <= REG_VOLT_MV_BASE;
         boostMv_reg <= BOOST_MV_BASE;
         inputDpmMv_reg <= DPM_MV_BASE;
      end else begin
         regulationMv_reg <= boostMode ? boostMv_next : regMv_next;
         boostMv_reg <= boostMv_next;
         inputDpmMv_reg <= dpmMv_next;
      end
   end

   // Short threshold source
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         thresholdSource_reg <= 1'b0;
      end else begin
         thresholdSource_reg <= shortThresholdRefSelect;
      end
   end

   assign inputLimitCode = inputLimitCode_reg;
   assign inputLimitMa = inputLimitMa_reg;
   assign inputLimitDisabled = inputLimitDisabled_reg;
   assign chargeSenseMv = chargeSenseMv_reg;
   assign terminationSenseMv = terminationSenseMv_reg;
   assign terminationEnable = terminationEnable_reg;
   assign regulationMv = regulationMv_reg;
   assign boostMv = boostMv_reg;
   assign inputDpmMv = inputDpmMv_reg;
   assign thresholdPinSourceEnable = thresholdSource_reg;
   assign hostRoleRequest = roleBus.roleActive;

endmodule // charger_config_registers

// ==== include/charger_config_pkg.sv ====
package charger_config_pkg;

   // ***************************************
   // Register map
   // ***************************************
   localparam logic [7:0] CHARGE_CURRENT_CONFIG_OFFSET = 8'h01;
   localparam logic [7:0] CHARGE_VOLTAGE_CONFIG_OFFSET = 8'h02;
   localparam logic [7:0] CHARGER_SPECIAL_CONFIG_OFFSET = 8'h03;

   localparam logic [7:0] CHARGE_CURRENT_CONFIG_RESET = 8'h01;
   localparam logic [7:0] CHARGE_VOLTAGE_CONFIG_RESET = 8'h19;
   localparam logic [7:0] CHARGER_SPECIAL_CONFIG_RESET = 8'h8a;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

   // ***************************************
   // Field positions
   // ***************************************
   localparam int LIMIT_SOURCE_BIT = 7;
   localparam int CHARGE_CODE_MSB = 6;
   localparam int CHARGE_CODE_LSB = 3;
   localparam int TERM_CODE_MSB = 2;
   localparam int TERM_CODE_LSB = 0;
   localparam int INPUT_LIMIT_MSB = 7;
   localparam int INPUT_LIMIT_LSB = 6;
   localparam int REG_VOLT_MSB = 5;
   localparam int REG_VOLT_LSB = 0;
   localparam int SHORT_REF_BIT = 7;
   localparam int HOST_POLARITY_BIT = 6;
   localparam int HOST_ENABLE_BIT = 5;
   localparam int TERM_ENABLE_BIT = 4;
   localparam int REDUCED_CURRENT_BIT = 3;
   localparam int DPM_CODE_MSB = 2;
   localparam int DPM_CODE_LSB = 0;

   // ***************************************
   // Code mappings, millivolts and milliamps
   // ***************************************
   localparam logic [3:0] CHARGE_CODE_SAT = 4'ha;
   localparam logic [12:0] CHARGE_MV_BASE = 13'h000b;
   localparam logic [12:0] CHARGE_MV_STEP = 13'h0002;
   localparam logic [12:0] CHARGE_MV_MAX = 13'h001f;
   localparam logic [12:0] REDUCED_CHARGE_MV = 13'h0003;
   localparam logic [12:0] TERM_MV_BASE = 13'h0001;
   localparam logic [12:0] TERM_MV_STEP = 13'h0001;
   localparam logic [5:0] REG_VOLT_CODE_SAT = 6'h2f;
   localparam logic [12:0] REG_VOLT_MV_BASE = 13'h0dac;
   localparam logic [12:0] REG_VOLT_MV_STEP = 13'h0014;
   localparam logic [12:0] REG_VOLT_MV_MAX = 13'h1158;
   localparam logic [12:0] BOOST_MV_BASE = 13'h1149;
   localparam logic [12:0] BOOST_MV_STEP = 13'h0017;
   localparam logic [12:0] BOOST_MV_MAX = 13'h157c;
   localparam logic [3:0] MAX_VOLT_CODE_SAT = 4'hc;
   localparam logic [12:0] MAX_VOLT_MV_BASE = 13'h1068;
   localparam logic [12:0] MAX_VOLT_MV_STEP = 13'h0014;
   localparam logic [12:0] DPM_MV_BASE = 13'h1068;
   localparam logic [12:0] DPM_MV_STEP = 13'h0050;

   localparam logic [1:0] INPUT_LIMIT_NONE = 2'h3;
   localparam logic [9:0] INPUT_LIMIT_MA_0 = 10'h064;
   localparam logic [9:0] INPUT_LIMIT_MA_1 = 10'h1f4;
   localparam logic [9:0] INPUT_LIMIT_MA_2 = 10'h3cf;
   localparam logic [9:0] INPUT_LIMIT_MA_NONE = 10'h000;

   localparam int SYNC_STAGES = 2;

endpackage

// ==== include/host_role_if.sv ====
`timescale 1ns/1ps
interface host_role_if;
   logic pinEnable;
   logic pinPolarity;
   logic roleActive;

   modport cfg (output pinEnable, output pinPolarity, input roleActive);
   modport qual (input pinEnable, input pinPolarity, output roleActive);
endinterface

// ==== core/host_role_qualifier.sv ====
`timescale 1ns/1ps
module host_role_qualifier
   import charger_config_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // External pin
   input wire logic hostRolePin,
   // Configuration and result
   host_role_if.qual roleBus
);

   logic [SYNC_STAGES-1:0] pinSync_reg;
   logic roleActive_reg;
   logic pinLevel;
   logic roleActive_next;

   // ***************************************
   // Pin synchroniser and qualification
   // ***************************************
   assign pinLevel = pinSync_reg[SYNC_STAGES-1];
   // Polarity low means the pin asserts low
   assign roleActive_next = roleBus.pinEnable &
                            (roleBus.pinPolarity ? pinLevel : ~pinLevel);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pinSync_reg <= '0;
         roleActive_reg <= 1'b0;
      end else begin
         pinSync_reg <= {pinSync_reg[SYNC_STAGES-2:0], hostRolePin};
         roleActive_reg <= roleActive_next;
      end
   end

   assign roleBus.roleActive = roleActive_reg;

endmodule // host_role_qualifier

// ==== tb/charger_config_props.sv ====
`timescale 1ns/1ps
// ***************************************
// Port checks
// ***************************************
module charger_config_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register access
   input wire logic [7:0] regAddr,
   input wire logic regRead,
   input wire logic [7:0] regReadData,
   input wire logic regReadValid,
   // Operating state
   input wire logic charging,
   input wire logic boostMode,
   input wire logic [3:0] maxChargeCurrentCode,
   input wire logic [3:0] maxRegulationVoltageCode,
   // Effective settings
   input wire logic [1:0] inputLimitCode,
   input wire logic [9:0] inputLimitMa,
   input wire logic inputLimitDisabled,
   input wire logic [12:0] chargeSenseMv,
   input wire logic [12:0] terminationSenseMv,
   input wire logic [12:0] regulationMv,
   input wire logic [12:0] inputDpmMv
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_read_valid_pulse: assert property (regRead |=> regReadValid)
      else $error("read without valid");
   a_valid_only_read: assert property (!regRead |=> !regReadValid)
      else $error("valid without read");
   a_unmapped_read_zero: assert property ((regRead && (regAddr == 8'h00 || regAddr > 8'h03)) |=>
      regReadData == 8'h00) else $error("unmapped read not zero");
   a_limit_none_flag: assert property (inputLimitDisabled == (inputLimitCode == 2'h3))
      else $error("limit flag wrong");
   a_limit_top_ma: assert property (inputLimitCode == 2'h2 |-> inputLimitMa == 10'h3cf)
      else $error("limit current wrong");
   a_term_range: assert property (terminationSenseMv >= 13'h0001 && terminationSenseMv <= 13'h0008)
      else $error("termination out of range");
   a_dpm_step: assert property (inputDpmMv <= 13'h1298 && (inputDpmMv - 13'h1068) % 80 == 0)
      else $error("input regulation off step");
   a_current_clamp: assert property ($past(charging) && $past(maxChargeCurrentCode) == 4'h0 |->
      chargeSenseMv <= 13'h000b) else $error("current not clamped");
   a_voltage_clamp: assert property ($past(charging) && !$past(boostMode) &&
      $past(maxRegulationVoltageCode) == 4'h0 |-> regulationMv <= 13'h1068) else $error("voltage not clamped");
endmodule // charger_config_props

bind charger_config_registers charger_config_props u_charger_config_props (.ref_clk, .rst, .regAddr, .regRead,
   .regReadData, .regReadValid, .charging, .boostMode, .maxChargeCurrentCode, .maxRegulationVoltageCode,
   .inputLimitCode, .inputLimitMa, .inputLimitDisabled, .chargeSenseMv, .terminationSenseMv, .regulationMv,
   .inputDpmMv);

// ==== tb/charger_host_model.sv ====
`timescale 1ns/1ps
// ***************************************
// Host register access
// ***************************************
module charger_host_model (
   // Clock
   input wire logic ref_clk,
   // Register port
   output logic [7:0] regAddr,
   output logic regWrite,
   output logic [7:0] regWriteData,
   output logic regRead,
   input wire logic [7:0] regReadData,
   input wire logic regReadValid
);
   initial begin
      regAddr = 8'h00;
      regWrite = 1'b0;
      regWriteData = 8'h00;
      regRead = 1'b0;
   end
   // Released lines show the inverse, never the last value
   task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      regAddr = a;
      regWriteData = d;
      regWrite = 1'b1;
      @(negedge ref_clk);
      regWrite = 1'b0;
      regAddr = ~a;
      regWriteData = ~d;
   endtask
   task automatic readReg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge ref_clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge ref_clk);
      regRead = 1'b0;
      regAddr = ~a;
      ok = regReadValid;
      d = regReadData;
   endtask
endmodule // charger_host_model

// ==== tb/test_charger_config_registers.sv ====
`timescale 1ns/1ps
module test_charger_config_registers;
   import charger_config_pkg::*;
   logic ref_clk, rst, charging, boostMode, hostRolePin, regWrite, regRead, regReadValid;
   logic [1:0] detectedLimitCode;
   logic [3:0] maxChargeCurrentCode, maxRegulationVoltageCode;
   logic [7:0] regAddr, regWriteData, regReadData;
   logic [1:0] inputLimitCode;
   logic [9:0] inputLimitMa;
   logic inputLimitDisabled, terminationEnable, thresholdPinSourceEnable, hostRoleRequest;
   logic [12:0] chargeSenseMv, terminationSenseMv, regulationMv, boostMv, inputDpmMv;
   int numErrors, nTests;

   charger_host_model u_charger_host_model (.ref_clk, .regAddr, .regWrite, .regWriteData, .regRead,
      .regReadData, .regReadValid);
   charger_config_registers u_charger_config_registers (.ref_clk, .rst, .regAddr, .regWrite, .regWriteData,
      .regRead, .regReadData, .regReadValid, .charging, .boostMode, .detectedLimitCode, .maxChargeCurrentCode,
      .maxRegulationVoltageCode, .hostRolePin, .inputLimitCode, .inputLimitMa, .inputLimitDisabled,
      .chargeSenseMv, .terminationSenseMv, .terminationEnable, .regulationMv, .boostMv, .inputDpmMv,
      .thresholdPinSourceEnable, .hostRoleRequest);

   // ***************************************
   // Shared tasks
   // ***************************************
   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      nTests++;
      if (seen !== exp) begin
         numErrors++;
         $display("Error at %0t: saw %0d expected %0d", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      if (numErrors == 0 && nTests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic settle;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic readCheck(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      u_charger_host_model.readReg(a, d, ok);
      check({12'h000, ok}, 13'h0001);
      check({5'h00, d}, {5'h00, exp});
   endtask

   // ***************************************
   // Scenarios
   // ***************************************
   task automatic resetValues;
      check(chargeSenseMv, 13'h0003);
      check(regulationMv, 13'h0fa0);
      check(boostMv, 13'h1388);
      check(inputDpmMv, 13'h1108);
      check(terminationSenseMv, 13'h0002);
      check({12'h000, thresholdPinSourceEnable}, 13'h0001);
      u_charger_host_model.writeReg(8'h09, 8'hff);
      readCheck(CHARGE_CURRENT_CONFIG_OFFSET, CHARGE_CURRENT_CONFIG_RESET);
      readCheck(CHARGE_VOLTAGE_CONFIG_OFFSET, CHARGE_VOLTAGE_CONFIG_RESET);
      readCheck(CHARGER_SPECIAL_CONFIG_OFFSET, CHARGER_SPECIAL_CONFIG_RESET);
      readCheck(8'h09, UNMAPPED_READ_VALUE);
   endtask
   task automatic codeSweep;
      for (int i = 0; i < 16; i++) begin
         u_charger_host_model.writeReg(CHARGER_SPECIAL_CONFIG_OFFSET, {i[1], 2'h0, i[0], 1'b0, i[2:0]});
         u_charger_host_model.writeReg(CHARGE_CURRENT_CONFIG_OFFSET, {1'b0, i[3:0], i[2:0]});
         settle();
         check(chargeSenseMv, 13'(11 + 2 * (i > 10 ? 10 : i)));
         check(terminationSenseMv, 13'(1 + i % 8));
         check(inputDpmMv, 13'(4200 + 80 * (i % 8)));
         check({12'h000, terminationEnable}, {12'h000, i[0]});
         check({12'h000, thresholdPinSourceEnable}, {12'h000, i[1]});
         readCheck(CHARGE_CURRENT_CONFIG_OFFSET, {1'b0, i[3:0], i[2:0]});
      end
   endtask
   task automatic clampSweep;
      int v, c, m, vr, mr;
      u_charger_host_model.writeReg(CHARGER_SPECIAL_CONFIG_OFFSET, 8'h00);
      u_charger_host_model.writeReg(CHARGE_CURRENT_CONFIG_OFFSET, 8'h78);
      charging = 1'b1;
      for (int j = 0; j < 16; j++) begin
         v = j * 4;
         maxChargeCurrentCode = 4'(j);
         maxRegulationVoltageCode = 4'(15 - j);
         u_charger_host_model.writeReg(CHARGE_VOLTAGE_CONFIG_OFFSET, {2'h0, 6'(v)});
         settle();
         c = j > 10 ? 10 : j;
         m = 15 - j > 12 ? 12 : 15 - j;
         vr = 3500 + 20 * (v > 47 ? 47 : v);
         mr = 4200 + 20 * m;
         check(chargeSenseMv, 13'(11 + 2 * c));
         check(regulationMv, 13'(vr < mr ? vr : mr));
         check(boostMv, 13'(v >= 47 ? 5500 : 4425 + 23 * v));
      end
      u_charger_host_model.writeReg(CHARGER_SPECIAL_CONFIG_OFFSET, 8'h08);
      settle();
      check(chargeSenseMv, 13'h0003);
      charging = 1'b0;
      boostMode = 1'b1;
      u_charger_host_model.writeReg(CHARGE_VOLTAGE_CONFIG_OFFSET, 8'h19);
      settle();
      check(regulationMv, 13'h1388);
      boostMode = 1'b0;
   endtask
   task automatic limitSweep;
      logic [1:0] e;
      logic [9:0] ma [4];
      ma = '{10'h064, 10'h1f4, 10'h3cf, 10'h000};
      for (int k = 0; k < 32; k++) begin
         detectedLimitCode = k[1:0];
         u_charger_host_model.writeReg(CHARGE_CURRENT_CONFIG_OFFSET, {k[4], 7'h00});
         u_charger_host_model.writeReg(CHARGE_VOLTAGE_CONFIG_OFFSET, {k[3:2], 6'h19});
         settle();
         e = (k[4] || k[3:2] > k[1:0]) ? k[3:2] : k[1:0];
         check({11'h000, inputLimitCode}, {11'h000, e});
         check({3'h0, inputLimitMa}, {3'h0, ma[e]});
         check({12'h000, inputLimitDisabled}, {12'h000, e == 2'h3});
      end
   endtask
   task automatic hostPin;
      for (int k = 0; k < 8; k++) begin
         u_charger_host_model.writeReg(CHARGER_SPECIAL_CONFIG_OFFSET, {1'b0, k[1], k[2], 5'h00});
         hostRolePin = k[0];
         repeat (5) @(negedge ref_clk);
         check({12'h000, hostRoleRequest}, {12'h000, k[2] & (k[0] == k[1])});
      end
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      numErrors++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      charging = 1'b0;
      boostMode = 1'b0;
      hostRolePin = 1'b1;
      detectedLimitCode = 2'h0;
      maxChargeCurrentCode = 4'hf;
      maxRegulationVoltageCode = 4'hf;
      numErrors = 0;
      nTests = 0;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      settle();
      resetValues();
      codeSweep();
      clampSweep();
      limitSweep();
      hostPin();
      conclude();
   end
endmodule // test_charger_config_registers
